// ===== core/aclm_cfg.svh
// Purpose: Constants for the access control entry matcher.
// Assumes: Included by its bare name from the package and core module.
// Notes:   Frame lengths exclude VLAN tags.
`ifndef ACLM_CFG_SVH
`define ACLM_CFG_SVH

// Shutdown applies only below this frame length
`define ACLM_SHUT_MAX_LEN   16'h05EE
// Field widths
`define ACLM_MAC_W          48
`define ACLM_LEN_W          16
`define ACLM_PORT_IDX_W     5
// Group bit in the first transmitted octet of a MAC address
`define ACLM_MAC_GROUP_BIT  40
`define ACLM_MAC_BCAST      48'hFFFF_FFFF_FFFF
// Reset values
`define ACLM_CNT_RST        1'b0
`define ACLM_PORT_DOWN_RST  1'b0

`endif

// ===== core/aclm_pkg.sv
// Purpose: Types for the access control entry matcher.
// Assumes: aclm_cfg.svh supplies the widths.
// Notes:   Frame class and entry frame type share one encoding.
`include "aclm_cfg.svh"

package aclm_pkg;

    // Frame class; ANY only has meaning on the entry side
    typedef enum logic [2:0] {
        ACLM_FT_ANY     = 3'b000,
        ACLM_FT_ETHTYPE = 3'b001,
        ACLM_FT_ARP     = 3'b010,
        ACLM_FT_IPV4    = 3'b011,
        ACLM_FT_IPV6    = 3'b100
    } aclm_ftype_t;

    typedef enum logic [0:0] {
        ACLM_SRC_ANY      = 1'b0,
        ACLM_SRC_SPECIFIC = 1'b1
    } aclm_src_mode_t;

    typedef enum logic [2:0] {
        ACLM_DST_ANY       = 3'b000,
        ACLM_DST_MULTICAST = 3'b001,
        ACLM_DST_BROADCAST = 3'b010,
        ACLM_DST_UNICAST   = 3'b011,
        ACLM_DST_SPECIFIC  = 3'b100
    } aclm_dst_mode_t;

    // One frame header as seen by the matcher
    typedef struct packed {
        logic                          valid;
        logic [`ACLM_PORT_IDX_W-1:0]   port;
        aclm_ftype_t                   ftype;
        logic [`ACLM_LEN_W-1:0]        len;
        logic [`ACLM_MAC_W-1:0]        src_mac;
        logic [`ACLM_MAC_W-1:0]        dst_mac;
    } aclm_frame_t;

    // Entry configuration from management software
    typedef struct packed {
        logic                          shut_en;
        aclm_ftype_t                   ftype;
        aclm_src_mode_t                src_mode;
        logic [`ACLM_MAC_W-1:0]        src_mac;
        aclm_dst_mode_t                dst_mode;
        logic [`ACLM_MAC_W-1:0]        dst_mac;
    } aclm_entry_t;

endpackage

// ===== core/aclm_entry_match.sv
// Purpose: Match ingress frame headers against one access control entry.
// Assumes: Frame and entry inputs come from logic on mclk_in.
// Notes:   Hit result, counter and port-down flags appear one edge after the frame.
`timescale 1ns/1ps

`include "aclm_cfg.svh"

module aclm_entry_match
    import aclm_pkg::*;
#(
    parameter int NUM_PORTS = 8,                        // Ingress ports served
    parameter int CNT_W     = 32                        // Hit counter width
) (
    input  wire logic                  mclk_in,         // Core clock, 125 MHz
    input  wire logic                  rst_n_in,        // Async reset, active low
    input  wire logic                  ce_in,           // Clock enable, freezes state
    input  wire aclm_frame_t           frame_in,        // Frame header, valid for one cycle
    input  wire aclm_entry_t           entry_in,        // Entry configuration
    input  wire logic                  cnt_clr_in,      // Clear hit counter
    input  wire logic [NUM_PORTS-1:0]  port_enable_in,  // Re-enable ports, one bit each
    output logic                       hit_out,         // Match pulse
    output logic [CNT_W-1:0]           hit_count_out,   // Hit counter
    output logic [NUM_PORTS-1:0]       port_down_out    // Ports disabled by the entry
);

    // Elaboration check on what the index field can address
    if (NUM_PORTS < 1 || NUM_PORTS > (1 << `ACLM_PORT_IDX_W) || CNT_W < 1) begin : g_bad
        $error("aclm_entry_match: unsupported NUM_PORTS or CNT_W");
    end

    // Group bit decides multicast versus unicast in two places
    function automatic logic mac_is_group(input logic [`ACLM_MAC_W-1:0] mac);
        mac_is_group = mac[`ACLM_MAC_GROUP_BIT];
    endfunction

    logic                  hit_reg;
    logic [CNT_W-1:0]      cnt_reg;
    logic [CNT_W-1:0]      cnt_next;
    logic [NUM_PORTS-1:0]  down_reg;
    logic [NUM_PORTS-1:0]  shut_now;
    logic                  type_ok;
    logic                  src_applies;
    logic                  src_ok;
    logic                  dst_ok;
    logic                  match_now;
    logic                  hit_now;
    logic                  short_frame;
    logic                  is_bcast;

    // Frame type condition; entry type Any accepts every class
    assign type_ok = (entry_in.ftype == ACLM_FT_ANY) || (entry_in.ftype == frame_in.ftype);

    // Source filter has no effect for other entry types
    assign src_applies = (entry_in.ftype == ACLM_FT_ETHTYPE) ||
                         (entry_in.ftype == ACLM_FT_ARP);

    // Source condition
    always_comb begin
        src_ok = 1'b1;
        if (src_applies && entry_in.src_mode == ACLM_SRC_SPECIFIC) begin
            src_ok = (frame_in.src_mac == entry_in.src_mac);
        end
    end

    assign is_bcast = (frame_in.dst_mac == `ACLM_MAC_BCAST);

    // Destination condition; broadcast is kept out of the multicast class
    always_comb begin
        case (entry_in.dst_mode)
            ACLM_DST_ANY: begin
                dst_ok = 1'b1;
            end
            ACLM_DST_MULTICAST: begin
                dst_ok = mac_is_group(frame_in.dst_mac) && !is_bcast;
            end
            ACLM_DST_BROADCAST: begin
                dst_ok = is_bcast;
            end
            ACLM_DST_UNICAST: begin
                dst_ok = !mac_is_group(frame_in.dst_mac);
            end
            ACLM_DST_SPECIFIC: begin
                dst_ok = (frame_in.dst_mac == entry_in.dst_mac);
            end
            default: begin
                dst_ok = 1'b0;
            end
        endcase
    end

    // All conditions on the same header
    assign match_now   = type_ok && src_ok && dst_ok;
    assign hit_now     = frame_in.valid && match_now;
    assign short_frame = (frame_in.len < `ACLM_SHUT_MAX_LEN);

    // Hit pulse
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hit_reg <= 1'b0;
        end else if (ce_in) begin
            hit_reg <= hit_now;
        end
    end

    // Counter; a hit in the clear cycle counts as the first one after it
    always_comb begin
        cnt_next = cnt_reg;
        if (cnt_clr_in) begin
            cnt_next = {CNT_W{1'b0}};
        end
        if (hit_now) begin
            cnt_next = cnt_next + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= {CNT_W{`ACLM_CNT_RST}};
        end else if (ce_in) begin
            cnt_reg <= cnt_next;
        end
    end

    // Per-port shutdown flags; a new shutdown beats a re-enable in the same cycle
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            assign shut_now[p] = hit_now && entry_in.shut_en && short_frame &&
                                 (frame_in.port == `ACLM_PORT_IDX_W'(p));

            always_ff @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    down_reg[p] <= `ACLM_PORT_DOWN_RST;
                end else if (ce_in) begin
                    if (shut_now[p]) begin
                        down_reg[p] <= 1'b1;
                    end else if (port_enable_in[p]) begin
                        down_reg[p] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign hit_out       = hit_reg;
    assign hit_count_out = cnt_reg;
    assign port_down_out = down_reg;

    // Assertions
    sequence frame_hit_s;
        ce_in && hit_now;
    endsequence

    sequence one_step_s;
        ##1 (hit_reg && cnt_reg == $past(cnt_next));
    endsequence

    shut_on_hit_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && |shut_now) |=> ((down_reg & $past(shut_now)) == $past(shut_now)))
        else $error("matching short frame did not shut its port");

    no_shut_dis_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && !entry_in.shut_en) |=> ((down_reg & ~$past(down_reg)) == '0))
        else $error("port shut while shutdown disabled");

    long_no_shut_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && frame_in.len >= `ACLM_SHUT_MAX_LEN) |=> ((down_reg & ~$past(down_reg)) == '0))
        else $error("long frame shut a port");

    count_step_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (frame_hit_s and (!cnt_clr_in)) |-> (one_step_s and
            ##1 (cnt_reg == $past(cnt_reg) + 1'b1)))
        else $error("hit counter did not step by one");

    count_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && !hit_now && !cnt_clr_in) |=> ($stable(cnt_reg) && !hit_reg))
        else $error("hit counter moved without a hit");

    src_scope_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!src_applies && type_ok && dst_ok) |-> match_now)
        else $error("source filter applied outside its frame types");

    src_any_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (entry_in.src_mode == ACLM_SRC_ANY && type_ok && dst_ok) |-> match_now)
        else $error("source address not treated as don't-care");

    src_spec_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (src_applies && entry_in.src_mode == ACLM_SRC_SPECIFIC &&
         frame_in.src_mac != entry_in.src_mac) |-> !match_now)
        else $error("source mismatch still matched");

    dst_class_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ((entry_in.dst_mode == ACLM_DST_BROADCAST && !is_bcast) ||
         (entry_in.dst_mode == ACLM_DST_UNICAST && frame_in.dst_mac[`ACLM_MAC_GROUP_BIT]) ||
         (entry_in.dst_mode == ACLM_DST_MULTICAST && !frame_in.dst_mac[`ACLM_MAC_GROUP_BIT]))
        |-> !match_now)
        else $error("destination class mismatch still matched");

    dst_spec_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (entry_in.dst_mode == ACLM_DST_SPECIFIC && frame_in.dst_mac != entry_in.dst_mac)
        |-> !match_now)
        else $error("destination mismatch still matched");

    all_cond_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && frame_in.valid && !(type_ok && src_ok && dst_ok)) |=> !hit_reg)
        else $error("hit without all conditions");

endmodule

// ===== testbench/aclm_frame_src.sv
// Purpose: Ingress path model that presents one frame header per call.
// Assumes: Caller enters send just after a rising edge.
// Notes:   Idle header fields show the inverse of the last frame, never stale values.
`timescale 1ns/1ps

module aclm_frame_src
    import aclm_pkg::*;
(
    input  wire logic  mclk_in,   // Core clock
    output aclm_frame_t frame_out // Header towards the matcher
);
    initial frame_out = '0;

    // Hold the header for exactly one edge, then scramble it
    task automatic send(input aclm_frame_t f);
        frame_out = f;
        @(posedge mclk_in);
        // One assignment, so the header never carries two values in one step
        #1 frame_out = aclm_frame_t'({1'b0, ~f[$bits(aclm_frame_t)-2:0]});
    endtask
endmodule

// ===== testbench/acl_entry_match_bench.sv
// Purpose: Self-checking bench for the entry matcher.
// Assumes: Outputs settle one edge after the header is taken.
// Notes:   Expected count is kept here, never read back from the design.
`timescale 1ns/1ps

module acl_entry_match_bench
    import aclm_pkg::*;
;
    localparam logic [47:0] M = 48'h0100_5E00_0001;
    localparam logic [47:0] B = 48'hFFFF_FFFF_FFFF;
    localparam logic [47:0] U = 48'h0011_2233_4455;
    logic        mclk = 0, rst_n = 0, ce = 1, clr = 0;
    logic [7:0]  pen  = '0;
    aclm_entry_t ent  = '0;
    aclm_frame_t frm;
    logic        hit;
    logic [31:0] cnt, exp_cnt = '0;
    logic [7:0]  pd;
    logic [47:0] adr [3] = '{M, B, U};
    int          mismatches = 0, cmp_count = 0;

    aclm_frame_src i_src (.mclk_in(mclk), .frame_out(frm));
    aclm_entry_match i_dut (.mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce),
        .frame_in(frm), .entry_in(ent), .cnt_clr_in(clr), .port_enable_in(pen),
        .hit_out(hit), .hit_count_out(cnt), .port_down_out(pd));

    initial begin
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // One header, then hit, count and port flags against expectation
    task automatic fr(input logic [4:0] p, input aclm_ftype_t t, input logic [15:0] l,
                      input logic [47:0] s, input logic [47:0] d, input logic h,
                      input logic [7:0] exp_pd);
        i_src.send('{valid: 1'b1, port: p, ftype: t, len: l, src_mac: s, dst_mac: d});
        if (h && ce) exp_cnt = exp_cnt + 32'h1;
        chk(64'(hit), 64'(h));
        chk(64'(cnt), 64'(exp_cnt));
        chk(64'(pd), 64'(exp_pd));
        // Let an idle edge pass so the next header is not driven in this time step
        @(posedge mclk);
        #1;
    endtask

    // Shutdown flags are sticky, so clear them between cases
    task automatic reopen;
        pen = 8'hFF;
        @(posedge mclk);
        #1 pen = 8'h00;
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        report_and_stop;
    end

    initial begin
        repeat (16) @(posedge mclk);
        #1 rst_n = 1;
        chk(64'(cnt), 64'h0);
        chk(64'(pd), 64'h0);
        ent.shut_en = 1'b1;
        fr(5'h3, ACLM_FT_IPV4, 16'h0040, U, U, 1'b1, 8'h08);
        reopen;
        fr(5'h5, ACLM_FT_ETHTYPE, 16'h05EE, U, U, 1'b1, 8'h00);
        fr(5'h5, ACLM_FT_ETHTYPE, 16'h05ED, U, U, 1'b1, 8'h20);
        reopen;
        ent.shut_en = 1'b0;
        fr(5'h2, ACLM_FT_ARP, 16'h0040, U, U, 1'b1, 8'h00);
        ent.src_mode = ACLM_SRC_SPECIFIC;
        ent.src_mac = U;
        ent.ftype = ACLM_FT_ETHTYPE;
        fr(5'h0, ACLM_FT_ETHTYPE, 16'h0040, B, U, 1'b0, 8'h00);
        fr(5'h0, ACLM_FT_ETHTYPE, 16'h0040, U, U, 1'b1, 8'h00);
        ent.ftype = ACLM_FT_ARP;
        fr(5'h0, ACLM_FT_ARP, 16'h0040, B, U, 1'b0, 8'h00);
        ent.ftype = ACLM_FT_IPV4;
        fr(5'h0, ACLM_FT_IPV4, 16'h0040, B, U, 1'b1, 8'h00);
        fr(5'h0, ACLM_FT_IPV6, 16'h0040, U, U, 1'b0, 8'h00);
        ent.src_mode = ACLM_SRC_ANY;
        ent.ftype = ACLM_FT_ARP;
        fr(5'h0, ACLM_FT_ARP, 16'h0040, B, U, 1'b1, 8'h00);
        // Every class mode against every class of address
        for (int m = 1; m < 4; m++) begin
            ent.dst_mode = aclm_dst_mode_t'(m);
            for (int a = 0; a < 3; a++) begin
                fr(5'h1, ACLM_FT_ARP, 16'h0040, U, adr[a], 1'(m == a + 1), 8'h00);
            end
        end
        ent.dst_mode = ACLM_DST_SPECIFIC;
        ent.dst_mac = M;
        fr(5'h1, ACLM_FT_ARP, 16'h0040, U, M, 1'b1, 8'h00);
        fr(5'h1, ACLM_FT_ARP, 16'h0040, U, M ^ 48'h1, 1'b0, 8'h00);
        // Frozen clock enable must ignore a matching header
        ce = 1'b0;
        fr(5'h1, ACLM_FT_ARP, 16'h0040, U, M, 1'b0, 8'h00);
        ce = 1'b1;
        clr = 1'b1;
        @(posedge mclk);
        #1 clr = 1'b0;
        chk(64'(cnt), 64'h0);
        report_and_stop;
    end
endmodule
